//--- cod_pkg.sv
/*
 Package for the operand address decoder: opcodes, cycle counts, addressing
 forms, segment codes, APB register map and packed carriers.
 Assumes a 32-bit APB slave on a single 125 MHz clock.
*/
`default_nettype none
package cod_pkg;
  // ==========================================
  // opcodes and cycle counts
  localparam logic [7:0] COD_OP_CARRY_INV = 8'hf5;
  localparam logic [7:0] COD_OP_BUS_HOLD = 8'hf0;
  localparam logic [7:0] COD_OP_IRQ_MASK = 8'hfa;
  localparam logic [7:0] COD_OP_IRQ_UNMASK = 8'hfb;
  localparam logic [7:0] COD_OP_DIR_CLEAR = 8'hfc;
  localparam logic [7:0] COD_OP_DIR_SET = 8'hfd;
  localparam logic [2:0] COD_SEG_PFX_HI = 3'h1;
  localparam logic [2:0] COD_SEG_PFX_LO = 3'h6;
  localparam logic [7:0] COD_CTRL_CYCLES = 8'h02;
  localparam logic [7:0] COD_EA_CYCLES = 8'h04;
  localparam logic [7:0] COD_WORD_XFER_CYCLES = 8'h04;
  // ==========================================
  // addressing forms and segments
  localparam logic [1:0] COD_FORM_NODISP = 2'h0;
  localparam logic [1:0] COD_FORM_DISP8 = 2'h1;
  localparam logic [1:0] COD_FORM_DISP16 = 2'h2;
  localparam logic [1:0] COD_FORM_REG = 2'h3;
  localparam logic [2:0] COD_SEL_DIRECT = 3'h6;
  localparam logic [1:0] COD_SEG_EXTRA = 2'h0;
  localparam logic [1:0] COD_SEG_CODE = 2'h1;
  localparam logic [1:0] COD_SEG_STACK = 2'h2;
  localparam logic [1:0] COD_SEG_DATA = 2'h3;
  // ==========================================
  // register map (byte addresses)
  localparam logic [7:0] COD_ADDR_CTRL = 8'h00;
  localparam logic [7:0] COD_ADDR_BYTES = 8'h04;
  localparam logic [7:0] COD_ADDR_BASE_SRC = 8'h08;
  localparam logic [7:0] COD_ADDR_FRAME_DST = 8'h0c;
  localparam logic [7:0] COD_ADDR_STATUS = 8'h10;
  localparam logic [7:0] COD_ADDR_OFFSET = 8'h14;
  localparam logic [7:0] COD_ADDR_ID = 8'h18;
  localparam logic [31:0] COD_ID_VALUE = 32'h0000c0de; // arbitrary value
  localparam logic [2:0] COD_FLAGS_RESET = 3'h0;
  typedef struct packed
  {
    logic [15:0] basew;
    logic [15:0] source_index;
    logic [15:0] frame_base;
    logic [15:0] dest_index;
  } cod_ptr_t;
  typedef struct packed
  {
    logic [15:0] offset;
    logic [1:0] seg;
    logic is_reg;
    logic [3:0] gpr_code;
    logic [1:0] disp_bytes;
    logic [7:0] cycles;
  } cod_res_t;
endpackage
`default_nettype wire

//--- cod_decoder.sv
/*
 Operand address decoder: software loads instruction bytes and pointer
 values over APB, starts a decode, and reads offset, segment, register
 selection, cycle count and the processor-control flags it maintains.
 Assumes a single APB master on pclk; no other bus or clock.
*/
// The APB interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module cod_decoder
(
  input wire logic pclk, // 125 MHz clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  output logic bus_lock // bus hold for next instruction
);
  import cod_pkg::*;

  // ==========================================
  // bus decode
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire hit_ctrl = paddr == COD_ADDR_CTRL;
  wire hit_bytes = paddr == COD_ADDR_BYTES;
  wire hit_bs = paddr == COD_ADDR_BASE_SRC;
  wire hit_fd = paddr == COD_ADDR_FRAME_DST;
  wire hit_st = paddr == COD_ADDR_STATUS;
  wire hit_off = paddr == COD_ADDR_OFFSET;
  wire hit_id = paddr == COD_ADDR_ID;
  wire mapped = hit_ctrl | hit_bytes | hit_bs | hit_fd | hit_st | hit_off | hit_id;

  // ==========================================
  // software-written registers
  // bytes_reg: [7:0] prefix, [15:8] opcode/modrm, [31:16] disp low,high
  logic [31:0] bytes_reg;
  logic [31:0] bs_reg;
  logic [31:0] fd_reg;
  logic [3:0] ctrl_reg; // [0] prefix valid [1] width [2] string dst [3] start
  cod_res_t res_reg;
  cod_res_t res_next;
  logic carry_reg;
  logic irq_en_reg;
  logic dir_reg;
  logic lock_reg;
  logic done_reg;
  cod_ptr_t ptr;

  assign ptr = '{basew: bs_reg[15:0], source_index: bs_reg[31:16],
                 frame_base: fd_reg[15:0], dest_index: fd_reg[31:16]};

  // ==========================================
  // field extraction
  wire [7:0] pfx = bytes_reg[7:0];
  wire [7:0] opb = bytes_reg[15:8];
  wire [1:0] form = opb[7:6];
  wire [2:0] gpr_sel = opb[5:3];
  wire [2:0] opnd_sel = opb[2:0];
  wire width = ctrl_reg[1];
  wire strdst = ctrl_reg[2];
  wire pfx_seg = ctrl_reg[0] && pfx[7:5] == COD_SEG_PFX_HI &&
                 pfx[2:0] == COD_SEG_PFX_LO;
  wire pfx_lock = ctrl_reg[0] && pfx == COD_OP_BUS_HOLD;
  wire is_direct = form == COD_FORM_NODISP && opnd_sel == COD_SEL_DIRECT;
  // displacement bytes sit right after the second byte, ahead of immediates
  wire [15:0] disp16 = {bytes_reg[31:24], bytes_reg[23:16]};
  wire [15:0] disp8 = {{8{bytes_reg[23]}}, bytes_reg[23:16]};

  // offset selection per addressing form
  logic [15:0] disp_val;
  logic [1:0] disp_cnt;
  always_comb
  begin
    disp_val = 16'h0000;
    disp_cnt = 2'h0;
    unique case (form)
      COD_FORM_NODISP:
      begin
        if (is_direct)
        begin
          disp_val = disp16;
          disp_cnt = 2'h2;
        end
      end
      COD_FORM_DISP8:
      begin
        disp_val = disp8;
        disp_cnt = 2'h1;
      end
      COD_FORM_DISP16:
      begin
        disp_val = disp16;
        disp_cnt = 2'h2;
      end
      COD_FORM_REG: disp_cnt = 2'h0;
    endcase
  end

  // base register sum per operand select
  logic [15:0] base_sum;
  always_comb
  begin
    unique case (opnd_sel)
      3'h0: base_sum = ptr.basew + ptr.source_index;
      3'h1: base_sum = ptr.basew + ptr.dest_index;
      3'h2: base_sum = ptr.frame_base + ptr.source_index;
      3'h3: base_sum = ptr.frame_base + ptr.dest_index;
      3'h4: base_sum = ptr.source_index;
      3'h5: base_sum = ptr.dest_index;
      3'h6: base_sum = is_direct ? 16'h0000 : ptr.frame_base;
      3'h7: base_sum = ptr.basew;
    endcase
  end

  // segment choice: string destination beats override beats defaults
  wire frame_based = !is_direct && (opnd_sel == 3'h2 || opnd_sel == 3'h3 || opnd_sel == 3'h6);
  logic [1:0] seg_sel;
  always_comb
  begin
    if (strdst)
      seg_sel = COD_SEG_EXTRA;
    else if (pfx_seg)
      seg_sel = pfx[4:3];
    else if (frame_based)
      seg_sel = COD_SEG_STACK;
    else
      seg_sel = COD_SEG_DATA;
  end

  // gpr code: bit 3 is width, low 3 bits index word or byte order
  wire [3:0] gpr_code = {width, gpr_sel};
  wire is_reg_form = form == COD_FORM_REG;
  // a memory operand pays the address time; word adds per transfer
  wire [7:0] mem_cycles = COD_EA_CYCLES +
                          (width ? COD_WORD_XFER_CYCLES : 8'h00);

  wire is_ctrl = opb == COD_OP_CARRY_INV || opb == COD_OP_IRQ_MASK ||
                 opb == COD_OP_IRQ_UNMASK || opb == COD_OP_DIR_CLEAR || opb == COD_OP_DIR_SET;

  always_comb
  begin
    res_next.offset = is_reg_form ? 16'h0000 : 16'(base_sum + disp_val);
    res_next.seg = seg_sel;
    res_next.is_reg = is_reg_form;
    res_next.gpr_code = is_reg_form ? {width, opnd_sel} : gpr_code;
    res_next.disp_bytes = disp_cnt;
    res_next.cycles = is_ctrl ? COD_CTRL_CYCLES : (is_reg_form ? 8'h00 : mem_cycles);
  end

  wire start = wr && hit_ctrl && pwdata[3];

  // ==========================================
  // state registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bytes_reg <= 32'h00000000;
      bs_reg <= 32'h00000000;
      fd_reg <= 32'h00000000;
      ctrl_reg <= 4'h0;
    end
    else
    begin
      if (wr && hit_bytes) bytes_reg <= pwdata;
      if (wr && hit_bs) bs_reg <= pwdata;
      if (wr && hit_fd) fd_reg <= pwdata;
      if (wr && hit_ctrl) ctrl_reg <= pwdata[3:0]; // start bit stands one cycle only
      else ctrl_reg[3] <= 1'b0;
    end
  end

  // decode result and flags update one cycle after the start write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      res_reg <= '0;
      {carry_reg, irq_en_reg, dir_reg} <= COD_FLAGS_RESET;
      lock_reg <= 1'b0;
      done_reg <= 1'b0;
    end
    else
    begin
      done_reg <= ctrl_reg[3] ? 1'b1 : (start ? 1'b0 : done_reg);
      if (ctrl_reg[3])
      begin
        res_reg <= res_next;
        lock_reg <= pfx_lock;
        if (opb == COD_OP_CARRY_INV) carry_reg <= !carry_reg;
        if (opb == COD_OP_IRQ_MASK) irq_en_reg <= 1'b0;
        if (opb == COD_OP_IRQ_UNMASK) irq_en_reg <= 1'b1;
        if (opb == COD_OP_DIR_CLEAR) dir_reg <= 1'b0;
        if (opb == COD_OP_DIR_SET) dir_reg <= 1'b1;
      end
    end
  end

  // ==========================================
  // read mux; always zero-wait, unmapped reads zero with error
  wire [31:0] status_word = {8'h00, res_reg.cycles, 2'h0, res_reg.disp_bytes,
                             res_reg.gpr_code, res_reg.is_reg, res_reg.seg,
                             done_reg, lock_reg, dir_reg, irq_en_reg, carry_reg};
  assign prdata = hit_ctrl ? {28'h0000000, ctrl_reg} :
                  hit_bytes ? bytes_reg :
                  hit_bs ? bs_reg :
                  hit_fd ? fd_reg :
                  hit_st ? status_word :
                  hit_off ? {16'h0000, res_reg.offset} :
                  hit_id ? COD_ID_VALUE : 32'h00000000;
  assign pready = 1'b1;
  assign pslverr = acc && !mapped;
  assign bus_lock = lock_reg;

  // ==========================================
  // checks
  // each check looks one edge after the start pulse, when results and flags land
  a_carry_flip: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_reg[3] && opb == COD_OP_CARRY_INV |=> carry_reg != $past(carry_reg))
    else $error("carry not inverted");
  a_lock_set: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_reg[3] && pfx_lock |=> bus_lock)
    else $error("bus hold not applied");
  a_lock_clear: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_reg[3] && !pfx_lock |=> !bus_lock)
    else $error("bus hold left on without prefix");
  a_irq_flag: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_reg[3] && opb == COD_OP_IRQ_MASK |=> !irq_en_reg && res_reg.cycles == 8'h02)
    else $error("interrupt enable not cleared");
  a_irq_set: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_reg[3] && opb == COD_OP_IRQ_UNMASK |=> irq_en_reg && res_reg.cycles == 8'h02)
    else $error("interrupt enable not set");
  a_dir_flag: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_reg[3] && opb == COD_OP_DIR_SET |=> dir_reg && res_reg.cycles == 8'h02)
    else $error("direction not set");
  a_dir_clear: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_reg[3] && opb == COD_OP_DIR_CLEAR |=> !dir_reg && res_reg.cycles == 8'h02)
    else $error("direction not cleared");
  a_reg_form: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_reg[3] && is_reg_form |=> res_reg.is_reg && res_reg.disp_bytes == 2'h0)
    else $error("register form wrong");
  a_nodisp_zero: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_reg[3] && form == 2'h0 && !is_direct |=> res_reg.disp_bytes == 2'h0)
    else $error("displacement counted for form without one");
  a_disp_sext: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_reg[3] && form == 2'h1 && opnd_sel == 3'h4 |=> res_reg.offset ==
      16'($past(ptr.source_index) + {{8{$past(bytes_reg[23])}}, $past(bytes_reg[23:16])}))
    else $error("byte displacement not sign extended");
  a_wide_disp: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_reg[3] && form == 2'h2 && opnd_sel == 3'h6 |=>
      res_reg.offset == 16'($past(ptr.frame_base) + $past(bytes_reg[31:16])))
    else $error("word displacement wrong");
  a_direct_addr: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_reg[3] && is_direct |=> res_reg.offset == $past(disp16) && res_reg.disp_bytes == 2'h2)
    else $error("direct address wrong");
  a_byte_cycles: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_reg[3] && !is_ctrl && !is_reg_form && !width |=> res_reg.cycles == 8'h04)
    else $error("byte memory cycles wrong");
  a_word_cycles: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_reg[3] && !is_ctrl && !is_reg_form && width |=> res_reg.cycles == 8'h08)
    else $error("word memory cycles wrong");
  a_override_seg: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_reg[3] && !strdst && pfx_seg |=> res_reg.seg == $past(pfx[4:3]))
    else $error("segment override not applied");
  a_string_seg: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_reg[3] && strdst |=> res_reg.seg == COD_SEG_EXTRA)
    else $error("string destination not in extra segment");
  a_frame_seg: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_reg[3] && !strdst && !pfx_seg && frame_based |=> res_reg.seg == COD_SEG_STACK)
    else $error("frame operand not in stack segment");
  a_data_seg: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_reg[3] && !strdst && !pfx_seg && !frame_based |=> res_reg.seg == COD_SEG_DATA)
    else $error("default operand not in data segment");
  // main scenarios: override, direct address, carry, string destination, word access
  c_override: cover property (@(posedge pclk) disable iff (!presetn) ctrl_reg[3] && pfx_seg);
  c_direct: cover property (@(posedge pclk) disable iff (!presetn) ctrl_reg[3] && is_direct);
  c_carry: cover property (@(posedge pclk) disable iff (!presetn) ctrl_reg[3] && opb == COD_OP_CARRY_INV);
  c_string: cover property (@(posedge pclk) disable iff (!presetn) ctrl_reg[3] && strdst);
  c_word: cover property (@(posedge pclk) disable iff (!presetn) ctrl_reg[3] && width);
endmodule // cod_decoder
`default_nettype wire

//--- tb_top.sv
/*
 self-checking bench for the operand address decoder over apb.
 assumes cod_pkg and cod_decoder are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import cod_pkg::*;
  typedef struct packed
  {
    logic [31:0] m;
    logic [31:0] e;
    logic er;
  } cod_note_t;
  localparam logic [7:0] OPS [6] = '{COD_OP_CARRY_INV, COD_OP_IRQ_UNMASK,
    COD_OP_DIR_SET, COD_OP_IRQ_MASK, COD_OP_DIR_CLEAR, COD_OP_CARRY_INV};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic bus_lock;
  cod_note_t notes[$];
  cod_note_t nt;
  int miscompares = 0;
  int n_tests = 0;
  logic cy = 1'b0;
  logic ie = 1'b0;
  logic df = 1'b0;
  logic [15:0] bx = 16'h0;
  logic [15:0] si = 16'h0;
  logic [15:0] bp = 16'h0;
  logic [15:0] di = 16'h0;
  cod_decoder cod_decoder_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus_lock(bus_lock));
  // ==========================================
  // clock and closing report
  always #4 pclk = ~pclk;
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ==========================================
  // monitor: each completed access retires the oldest note
  always @(posedge pclk)
  begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1)
    begin
      nt = notes.pop_front();
      n_tests++;
      if (((prdata & nt.m) !== (nt.e & nt.m)) || (pslverr !== nt.er))
      begin
        miscompares++;
        $display("Error at %0t: got %h/%h expected %h/%h", $time, prdata & nt.m,
          pslverr, nt.e & nt.m, nt.er);
      end
    end
  end
  // ==========================================
  // apb master; request held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
    input logic [31:0] m, input logic [31:0] e, input logic er);
    int i;
    notes.push_back('{m, e, er});
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    if (i == 16)
    begin
      miscompares++;
      final_report();
    end
    else
    begin
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 32'h0, 1'b0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0, m, e, 1'b0);
  endtask
  // bus hold pin is a level, settled an edge before this look
  task automatic chk_lock(input logic e);
    n_tests++;
    if (bus_lock !== e)
    begin
      miscompares++;
      $display("Error at %0t: bus_lock %h expected %h", $time, bus_lock, e);
    end
  endtask
  // load bytes and pointers, then start; results land before the next access
  task automatic dec(input logic pv, input logic [7:0] pfx, input logic [7:0] mr,
    input logic [7:0] lo, input logic [7:0] hi, input logic w, input logic sd);
    wr(COD_ADDR_BYTES, {hi, lo, mr, pfx});
    wr(COD_ADDR_BASE_SRC, {si, bx});
    wr(COD_ADDR_FRAME_DST, {di, bp});
    wr(COD_ADDR_CTRL, {28'h0, 1'b1, sd, w, pv});
  endtask
  task automatic ctl(input logic [7:0] op);
    dec(1'b0, 8'h00, op, 8'h00, 8'h00, 1'b0, 1'b0);
    if (op == COD_OP_CARRY_INV)
      cy = ~cy;
    if (op == COD_OP_IRQ_MASK || op == COD_OP_IRQ_UNMASK)
      ie = op[0];
    if (op == COD_OP_DIR_CLEAR || op == COD_OP_DIR_SET)
      df = op[0];
    rd(COD_ADDR_STATUS, 32'h00ff0017, {8'h0, COD_CTRL_CYCLES, 11'h0, 1'b1, 1'b0, df, ie, cy});
  endtask
  // memory-form model: offset, segment, displacement count and cycles
  task automatic mem(input logic pv, input logic [1:0] ss, input logic [7:0] mr,
    input logic [7:0] lo, input logic [7:0] hi, input logic w, input logic sd);
    logic [15:0] dsp;
    logic [15:0] ofs;
    logic [1:0] nb;
    logic [1:0] sg;
    logic drc;
    drc = (mr[7:6] == COD_FORM_NODISP) && (mr[2:0] == COD_SEL_DIRECT);
    dsp = (mr[7:6] == COD_FORM_DISP8) ? {{8{lo[7]}}, lo} : 16'h0;
    dsp = (mr[7:6] == COD_FORM_DISP16) ? {hi, lo} : dsp;
    nb = drc ? 2'h2 : mr[7:6];
    case (mr[2:0])
      3'h0: ofs = bx + si;
      3'h1: ofs = bx + di;
      3'h2: ofs = bp + si;
      3'h3: ofs = bp + di;
      3'h4: ofs = si;
      3'h5: ofs = di;
      3'h6: ofs = bp;
      default: ofs = bx;
    endcase
    ofs = drc ? {hi, lo} : ofs + dsp;
    if (sd)
      sg = COD_SEG_EXTRA;
    else if (pv)
      sg = ss;
    else if (mr[2:1] == 2'h1 || (mr[2:0] == 3'h6 && !drc))
      sg = COD_SEG_STACK;
    else
      sg = COD_SEG_DATA;
    dec(pv, {COD_SEG_PFX_HI, ss, COD_SEG_PFX_LO}, mr, lo, hi, w, sd);
    rd(COD_ADDR_OFFSET, 32'h0000ffff, {16'h0, ofs});
    rd(COD_ADDR_STATUS, 32'h00ff30f7, {8'h0, COD_EA_CYCLES + (w ? COD_WORD_XFER_CYCLES : 8'h0),
      4'(nb), 4'h0, 1'b0, sg, 1'b1, 1'b0, df, ie, cy});
  endtask
  // ==========================================
  // main sequence
  initial
  begin
    int k;
    void'($urandom(28));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(COD_ADDR_STATUS, 32'hffffffff, 32'h0);
    rd(COD_ADDR_ID, 32'hffffffff, COD_ID_VALUE);
    apb(1'b1, 8'h1c, 32'hffffffff, 32'h0, 32'h0, 1'b1);
    apb(1'b0, 8'h1c, 32'h0, 32'hffffffff, 32'h0, 1'b1);
    rd(COD_ADDR_ID, 32'hffffffff, COD_ID_VALUE);
    for (k = 0; k < 6; k++)
      ctl(OPS[k]);
    dec(1'b1, COD_OP_BUS_HOLD, 8'hc0, 8'h00, 8'h00, 1'b0, 1'b0);
    rd(COD_ADDR_STATUS, 32'h00000008, 32'h00000008);
    chk_lock(1'b1);
    for (k = 0; k < 16; k++)
    begin
      dec(1'b0, 8'h00, {5'h18, 3'(k)}, 8'h00, 8'h00, k[3], 1'b0);
      rd(COD_ADDR_STATUS, 32'h00ff3f97,
        {20'h0, 4'(k), 1'b1, 2'h0, 1'b1, 1'b0, df, ie, cy});
    end
    chk_lock(1'b0);
    // odd passes use a byte displacement off source, even ones a word off frame
    for (k = 0; k < 4; k++)
      mem(1'b1, 2'(k), k[0] ? 8'h54 : 8'h96, 8'h80, 8'h12, 1'b1, 1'b0);
    mem(1'b1, COD_SEG_CODE, 8'h0d, 8'h34, 8'h56, 1'b0, 1'b1);
    for (k = 0; k < 40; k++)
    begin
      bx = 16'($urandom);
      si = 16'($urandom);
      bp = 16'($urandom);
      di = 16'($urandom);
      mem(1'($urandom), 2'($urandom), {2'($urandom_range(2, 0)), 6'($urandom)},
        8'($urandom), 8'($urandom), 1'($urandom), 1'($urandom));
    end
    repeat (4) @(posedge pclk);
    final_report();
  end
endmodule // tb_top
`default_nettype wire
